// ==== design/sadc_regs.vh ====
// Functional notes
// RULE_01: Mode 00 off, 01 single, 11 repeat.
// RULE_02: Start bit begins one single conversion.
// RULE_03: Start bit self-clears, reads zero.
// RULE_04: Software never restarts during running conversion.
// RULE_05: Channel code selects input zero to fifteen.
// RULE_06: Software changes channel only when idle.
// RULE_07: Input control bit one disables inputs.
// RULE_08: Software disables inputs when none used.
// RULE_09: Standby resets control registers, blocks writes.
// RULE_10: Ladder bit: zero during conversion, one always.
// RULE_11: Time code gives 39 to 1248 cycles.
// RULE_12: Software writes bit0 zero, bit4 one.
// RULE_13: Control two bits 7:6 read undefined.
// RULE_14: Software keeps conversion time above minimum.
// RULE_15: Result split high byte, low two bits.
// RULE_16: Completion stores result, sets done, interrupts.
// RULE_17: Reading high result clears done flag.
// RULE_18: Busy set at start, cleared finish/standby.
// RULE_19: Result low bits 3:0 read unstable.
// RULE_20: Repeat mode restarts after each completion.
// RULE_21: Mode 00 aborts, partial result discarded.
// RULE_22: New start clears done, keeps old result.
// RULE_23: Standby abandons conversion, no resume.
// RULE_24: Count clock cycles to selected time.
// RULE_25: Start ignored in off or reserved mode.
`ifndef SADC_REGS_VH
`define SADC_REGS_VH
`define SADC_IDX_CTRL1    8'h1C
`define SADC_IDX_CTRL2    8'h1D
`define SADC_IDX_RES_LO   8'h1E
`define SADC_IDX_RES_HI   8'h1F
`define SADC_CTRL1_RST    8'h10
`define SADC_CTRL2_RST    8'h10
`define SADC_RES_RST      8'h00
`define SADC_START_BIT    7
`define SADC_MODE_HI      6
`define SADC_MODE_LO      5
`define SADC_AIDIS_BIT    4
`define SADC_CH_HI        3
`define SADC_CH_LO        0
`define SADC_LADDER_BIT   5
`define SADC_TIME_HI      3
`define SADC_TIME_LO      1
`define SADC_DONE_BIT     5
`define SADC_BUSY_BIT     4
`define SADC_MODE_OFF     2'h0
`define SADC_MODE_SINGLE  2'h1
`define SADC_MODE_REPEAT  2'h3
`define SADC_CYC_39       11'h027
`define SADC_CYC_78       11'h04E
`define SADC_CYC_156      11'h09C
`define SADC_CYC_312      11'h138
`define SADC_CYC_624      11'h270
`define SADC_CYC_1248     11'h4E0
`define SADC_TIME_RSV_A   3'h1
`define SADC_TIME_RSV_B   3'h7
`endif

// ==== design/sadc_timer.v ====
`include "sadc_regs.vh"
module sadc_timer #(
   parameter CW = 11
) (
   input  wire          core_clk_i,  // Core clock
   input  wire          rst_n_i,     // Sync reset, low
   input  wire          run_i,       // Conversion in progress
   input  wire          kick_i,      // Restart count
   input  wire [2:0]    time_code_i, // Conversion time code
   output wire          expire_o     // Final cycle of count
);
   reg  [CW-1:0] cnt_q;
   reg  [CW-1:0] cnt_d;
   wire [CW-1:0] limit;

   function [CW-1:0] sadc_cycles;
      input [2:0] code;
      begin
         case (code)
            3'h0:    sadc_cycles = `SADC_CYC_39;
            3'h2:    sadc_cycles = `SADC_CYC_78;
            3'h3:    sadc_cycles = `SADC_CYC_156;
            3'h4:    sadc_cycles = `SADC_CYC_312;
            3'h5:    sadc_cycles = `SADC_CYC_624;
            3'h6:    sadc_cycles = `SADC_CYC_1248;
            // Reserved codes fall back to the slowest, safest time
            default: sadc_cycles = `SADC_CYC_1248;
         endcase
      end
   endfunction

   assign limit    = sadc_cycles(time_code_i); // [RULE_11]
   assign expire_o = run_i && !kick_i && (cnt_q == limit - {{(CW-1){1'b0}}, 1'b1}); // [RULE_24]

   always @* begin
      cnt_d = cnt_q;
      if (kick_i || !run_i || expire_o) begin
         cnt_d = {CW{1'b0}};
      end else begin
         cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1}; // [RULE_24]
      end
   end

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cnt_q <= {CW{1'b0}};
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule

// ==== design/sadc_apb_if.v ====
`include "sadc_regs.vh"
module sadc_apb_if (
   input  wire          core_clk_i,  // Core clock
   input  wire          rst_n_i,     // Sync reset, low
   input  wire          psel_i,      // APB select
   input  wire          penable_i,   // APB enable
   input  wire          pwrite_i,    // APB direction
   input  wire [11:0]   paddr_i,     // APB byte address
   input  wire [31:0]   pwdata_i,    // APB write data
   input  wire [7:0]    rdata_i,     // Register read value
   output wire          pready_o,    // Always ready
   output wire          pslverr_o,   // Unmapped access
   output wire [31:0]   prdata_o,    // APB read data
   output wire          wr_o,        // Write strobe
   output wire          rd_o,        // Read strobe
   output wire [1:0]    sel_o,       // Register index low bits
   output wire [7:0]    wdata_o      // Write byte
);
   // All four registers share one 16-byte window starting at the first control word
   localparam [7:0] BASE_IDX = `SADC_IDX_CTRL1;

   wire hit;
   wire access;

   assign access    = psel_i && penable_i;
   assign hit       = (paddr_i[11:4] == {2'b00, BASE_IDX[7:2]}) && (paddr_i[1:0] == 2'b00);
   assign pready_o  = 1'b1;
   assign pslverr_o = access && !hit;
   assign wr_o      = access && hit && pwrite_i;
   assign rd_o      = access && hit && !pwrite_i;
   assign sel_o     = paddr_i[3:2];
   assign wdata_o   = pwdata_i[7:0];
   assign prdata_o  = rd_o ? {24'h000000, rdata_i} : 32'h00000000;
endmodule

// ==== design/sadc_ctrl.v ====
// Added by the designer: the APB slave port.
`include "sadc_regs.vh"
module sadc_ctrl #(
   parameter CW = 11
) (
   input  wire          core_clk_i,     // Core clock, high_freq_osc_clock
   input  wire          rst_n_i,        // Sync reset, low
   input  wire          standby_i,      // Stop, slow or sleep entered
   input  wire          psel_i,         // APB select
   input  wire          penable_i,      // APB enable
   input  wire          pwrite_i,       // APB direction
   input  wire [11:0]   paddr_i,        // APB byte address
   input  wire [31:0]   pwdata_i,       // APB write data
   output wire          pready_o,       // APB ready
   output wire          pslverr_o,      // APB error
   output wire [31:0]   prdata_o,       // APB read data
   input  wire [9:0]    sar_result_i,   // Comparator result word
   output reg  [3:0]    channel_sel_o,  // Analog mux select
   output reg           ain_disable_o,  // Analog inputs disabled
   output reg           ladder_on_o,    // Ladder DAC connected
   output reg           sample_o,       // Converter active
   output reg           conv_done_irq_o // Completion pulse
);
   localparam ST_IDLE = 2'b01;
   localparam ST_CONV = 2'b10;

   reg  [1:0]   state_q;
   reg  [1:0]   state_d;
   reg  [7:0]   ctrl1_q;
   reg  [7:0]   ctrl2_q;
   reg  [7:0]   res_hi_q;
   reg  [1:0]   res_lo_q;
   reg          done_q;
   reg          done_d;
   reg  [7:0]   rdata;
   reg  [1:0]   stby_sync_q;
   wire         stby;
   wire         wr;
   wire         rd;
   wire [1:0]   sel;
   wire [7:0]   wdata;
   wire [1:0]   mode;
   wire         mode_ok;
   wire         start_req;
   wire         expire;
   wire         kick;
   wire         abort;
   wire [7:0]   idx;
   wire [1:0]   wmode;
   wire         wmode_ok;
   wire         wr_c1;

   // Only single and repeat modes may run a conversion
   function sadc_mode_runs;
      input [1:0] m;
      begin
         sadc_mode_runs = (m == `SADC_MODE_SINGLE) || (m == `SADC_MODE_REPEAT);
      end
   endfunction

   sadc_apb_if u_apb (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .psel_i     (psel_i),
      .penable_i  (penable_i),
      .pwrite_i   (pwrite_i),
      .paddr_i    (paddr_i),
      .pwdata_i   (pwdata_i),
      .rdata_i    (rdata),
      .pready_o   (pready_o),
      .pslverr_o  (pslverr_o),
      .prdata_o   (prdata_o),
      .wr_o       (wr),
      .rd_o       (rd),
      .sel_o      (sel),
      .wdata_o    (wdata)
   );

   // Standby comes from the power manager, not this clock's logic
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         stby_sync_q <= 2'b00;
      end else begin
         stby_sync_q <= {stby_sync_q[0], standby_i};
      end
   end
   assign stby = stby_sync_q[1];

   assign idx       = {6'h07, sel};
   assign mode      = ctrl1_q[`SADC_MODE_HI:`SADC_MODE_LO];
   assign wr_c1     = wr && (idx == `SADC_IDX_CTRL1);
   assign wmode     = wdata[`SADC_MODE_HI:`SADC_MODE_LO];
   assign mode_ok   = sadc_mode_runs(mode); // [RULE_01]
   assign wmode_ok  = sadc_mode_runs(wmode); // [RULE_01]
   assign start_req = wr_c1 && wdata[`SADC_START_BIT] && !stby && wmode_ok; // [RULE_25]
   // The mode 00 write itself stops the run, so no extra cycle is converted
   assign abort     = (state_q == ST_CONV)
                      && (stby || (wr_c1 ? !wmode_ok : !mode_ok)); // [RULE_21] [RULE_23]
   assign kick      = start_req; // [RULE_02]

   sadc_timer #(
      .CW (CW)
   ) u_timer (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .run_i       (state_q == ST_CONV && !abort),
      .kick_i      (kick),
      .time_code_i (ctrl2_q[`SADC_TIME_HI:`SADC_TIME_LO]),
      .expire_o    (expire)
   );

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (kick) begin
               state_d = ST_CONV; // [RULE_18]
            end
         end
         ST_CONV: begin
            if (abort) begin
               state_d = ST_IDLE; // [RULE_23]
            end else if (kick) begin
               state_d = ST_CONV;
            end else if (expire && mode != `SADC_MODE_REPEAT) begin // [RULE_20]
               state_d = ST_IDLE; // [RULE_18]
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // Completion beats a same-cycle read so the event is never lost
   always @* begin
      done_d = done_q;
      if (stby) begin
         done_d = 1'b0;
      end else if (expire && !abort) begin
         done_d = 1'b1; // [RULE_16]
      end else if (kick) begin
         done_d = 1'b0; // [RULE_22]
      end else if (rd && idx == `SADC_IDX_RES_HI) begin
         done_d = 1'b0; // [RULE_17]
      end
   end

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_q         <= ST_IDLE;
         ctrl1_q         <= `SADC_CTRL1_RST;
         ctrl2_q         <= `SADC_CTRL2_RST;
         res_hi_q        <= `SADC_RES_RST;
         res_lo_q        <= 2'b00;
         done_q          <= 1'b0;
         conv_done_irq_o <= 1'b0;
      end else begin
         state_q         <= state_d;
         done_q          <= done_d;
         conv_done_irq_o <= expire && !abort && !stby; // [RULE_16]
         if (stby) begin
            ctrl1_q  <= `SADC_CTRL1_RST; // [RULE_09]
            ctrl2_q  <= `SADC_CTRL2_RST; // [RULE_09]
            res_hi_q <= `SADC_RES_RST;
            res_lo_q <= 2'b00;
         end else begin
            if (wr && idx == `SADC_IDX_CTRL1) begin
               // Start bit is never stored, so it always reads zero
               ctrl1_q <= {1'b0, wdata[6:0]}; // [RULE_03]
            end
            if (wr && idx == `SADC_IDX_CTRL2) begin
               ctrl2_q <= {2'b00, wdata[5:0]};
            end
            if (expire && !abort) begin
               res_hi_q <= sar_result_i[9:2]; // [RULE_15] [RULE_16]
               res_lo_q <= sar_result_i[1:0]; // [RULE_15]
            end
         end
      end
   end

   always @* begin
      rdata = 8'h00;
      if (idx == `SADC_IDX_CTRL1) begin
         rdata = ctrl1_q;
      end else if (idx == `SADC_IDX_CTRL2) begin
         rdata = {2'b00, ctrl2_q[5:0]}; // [RULE_13]
      end else if (idx == `SADC_IDX_RES_LO) begin
         // Low nibble undefined for software; driven as zero here
         rdata = {res_lo_q, done_q, state_q == ST_CONV, 4'h0}; // [RULE_15] [RULE_19]
      end else begin
         rdata = res_hi_q;
      end
   end

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         channel_sel_o <= 4'h0;
         ain_disable_o <= 1'b1;
         ladder_on_o   <= 1'b0;
         sample_o      <= 1'b0;
      end else begin
         channel_sel_o <= ctrl1_q[`SADC_CH_HI:`SADC_CH_LO]; // [RULE_05]
         ain_disable_o <= ctrl1_q[`SADC_AIDIS_BIT]; // [RULE_07]
         ladder_on_o   <= ctrl2_q[`SADC_LADDER_BIT] || (state_d == ST_CONV); // [RULE_10]
         sample_o      <= (state_d == ST_CONV); // [RULE_20]
      end
   end
endmodule

// ==== verif/sadc_analog_model.sv ====
// Stands in for the comparator chain: the word encodes the selected input
module sadc_analog_model (
   input  wire logic       sample_i,  // Converter active
   input  wire logic [3:0] channel_i, // Selected input
   output logic      [9:0] result_o   // Result word
);
   timeunit 1ns;
   timeprecision 1ps;
   // Inverted when idle so a stale word never looks valid
   assign result_o = sample_i ? {channel_i, 6'h2D} : ~{channel_i, 6'h2D};
endmodule

// ==== verif/sadc_ctrl_props.sv ====
module sadc_ctrl_props (
   input wire logic        core_clk_i, rst_n_i, standby_i, psel_i, penable_i, pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i, prdata_o,
   input wire logic        pready_o, pslverr_o, ain_disable_o, ladder_on_o, sample_o,
   input wire logic        conv_done_irq_o,
   input wire logic [9:0]  sar_result_i,
   input wire logic [3:0]  channel_sel_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire acc = psel_i && penable_i;
   wire map = paddr_i[11:4] == 8'h07 && paddr_i[1:0] == 2'h0;
   wire wc1 = acc && pwrite_i && paddr_i == 12'h070;
   ready_always_a: assert property (pready_o) else $error("pready low");
   unmapped_err_a: assert property (acc && !map |-> pslverr_o) else $error("no slverr");
   mapped_ok_a: assert property (acc && map |-> !pslverr_o && prdata_o[31:8] == 24'h0)
      else $error("bad mapped access");
   irq_pulse_a: assert property (conv_done_irq_o |=> !conv_done_irq_o) else $error("irq long");
   irq_cause_a: assert property (conv_done_irq_o |-> $past(sample_o, 2)) else $error("stray irq");
   // Standby low for three cycles so the synchroniser cannot veto the start
   single_start_a: assert property ((!standby_i)[*3] ##0 (wc1 && pwdata_i[7:5] == 3'h5)
      |=> sample_o) else $error("start lost");
   rsv_mode_a: assert property (wc1 && pwdata_i[6:5] == 2'h2 && !sample_o |=> !sample_o)
      else $error("reserved mode ran");
   mode_abort_a: assert property (wc1 && pwdata_i[6:5] == 2'h0 |=> !sample_o)
      else $error("abort ignored");
   standby_clear_a: assert property (standby_i[*4] |=> !sample_o && ain_disable_o
      && channel_sel_o == 4'h0) else $error("standby kept state");
   ladder_conv_a: assert property (sample_o |-> ladder_on_o) else $error("ladder off");
endmodule
bind sadc_ctrl sadc_ctrl_props u_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
   .standby_i(standby_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .ain_disable_o(ain_disable_o), .ladder_on_o(ladder_on_o),
   .sample_o(sample_o), .conv_done_irq_o(conv_done_irq_o), .sar_result_i(sar_result_i),
   .channel_sel_o(channel_sel_o));

// ==== verif/tb_sadc_ctrl.sv ====
module tb_sadc_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_i = 0, rst_n_i = 0, standby_i = 0;
   logic        psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, q;
   wire         pready_o, pslverr_o, ain_disable_o, ladder_on_o, sample_o, conv_done_irq_o;
   wire  [31:0] prdata_o;
   wire  [9:0]  sar_result_i;
   wire  [3:0]  channel_sel_o;
   logic        err;
   int          fails = 0, checks_done = 0;
   time         ts;
   sadc_ctrl dut (.*);
   sadc_analog_model u_ana (.sample_i(sample_o), .channel_i(channel_sel_o),
      .result_o(sar_result_i));
   initial forever #2 core_clk_i = ~core_clk_i;
   task summarize;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   // One idle edge first, so a release never meets a new request in one step
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge core_clk_i);
      psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= {24'h0, d}; penable_i <= 0;
      @(posedge core_clk_i);
      penable_i <= 1;
      for (n = 0; n < 16; n++) begin
         @(posedge core_clk_i);
         if (pready_o === 1'b1) break;
      end
      if (n == 16) begin fails++; summarize(); end
      q = prdata_o;
      err = pslverr_o;
      psel_i <= 0; penable_i <= 0;
      #1;
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e, input string nm);
      apb(0, a, 8'h00);
      chk(nm, q, {24'h0, e});
   endtask
   // Pin outputs follow the registers one edge later
   task tick;
      @(posedge core_clk_i);
      #1;
   endtask
   task start(input logic [7:0] d);
      apb(1, 12'h070, d);
      ts = $time;
   endtask
   task wait_irq(input int cyc);
      int n;
      for (n = 0; n < 1400; n++) begin
         @(posedge core_clk_i); #1;
         if (conv_done_irq_o === 1'b1) break;
      end
      if (n == 1400) begin fails++; summarize(); end
      if (cyc > 0) chk("conv cycles", 32'(($time - ts) / 4), 32'(cyc));
   endtask
   task t_reset;
      rd(12'h070, 8'h10, "ctrl1 rst");
      rd(12'h074, 8'h10, "ctrl2 rst");
      rd(12'h07C, 8'h00, "res rst");
      apb(0, 12'h080, 8'h00);
      chk("unmapped err", err, 1);
      chk("ain rst", ain_disable_o, 1);
   endtask
   task t_times;
      logic [2:0] code[6] = '{0, 2, 3, 4, 5, 6};
      int         cyc[6] = '{39, 78, 156, 312, 624, 1248};
      logic [3:0] ch;
      for (int i = 0; i < 6; i++) begin
         ch = 4'(i * 3);
         apb(1, 12'h074, {4'h1, code[i], 1'b0});
         start({4'hA, ch});
         tick();
         chk("channel", channel_sel_o, ch);
         chk("ain on", ain_disable_o, 0);
         rd(12'h070, {4'h2, ch}, "start clr");
         apb(0, 12'h078, 8'h00);
         chk("busy", q[4], 1);
         wait_irq(cyc[i]);
         rd(12'h078, 8'h60, "res lo");
         rd(12'h07C, {ch, 4'hB}, "res hi");
         rd(12'h078, 8'h40, "done clr");
      end
   endtask
   task t_misc;
      apb(1, 12'h074, 8'h30);
      tick();
      chk("ladder on", ladder_on_o, 1);
      apb(1, 12'h074, 8'h10);
      tick();
      chk("ladder idle", ladder_on_o, 0);
      start(8'hD0);
      chk("rsv mode", sample_o, 0);
      start(8'h90);
      chk("off mode", sample_o, 0);
      tick();
      chk("ain off", ain_disable_o, 1);
      start(8'hA5);
      wait_irq(39);
      start(8'hA5);
      rd(12'h078, 8'h50, "restart done");
      rd(12'h07C, 8'h5B, "old result");
      wait_irq(39);
      start(8'hE7);
      wait_irq(39);
      wait_irq(0);
      chk("repeat", sample_o, 1);
      apb(1, 12'h070, 8'h07);
      chk("abort", sample_o, 0);
      rd(12'h07C, 8'h7B, "kept result");
      repeat (60) begin
         @(posedge core_clk_i); #1;
         chk("no irq", conv_done_irq_o, 0);
      end
   endtask
   task t_standby;
      start(8'hA1);
      @(posedge core_clk_i);
      standby_i <= 1;
      repeat (6) @(posedge core_clk_i);
      #1;
      chk("stby busy", sample_o, 0);
      apb(1, 12'h070, 8'h23);
      rd(12'h070, 8'h10, "stby write");
      rd(12'h07C, 8'h00, "stby result");
      @(posedge core_clk_i);
      standby_i <= 0;
      repeat (4) @(posedge core_clk_i);
      #1;
      chk("no resume", sample_o, 0);
   endtask
   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_n_i <= 1;
      t_reset();
      t_times();
      t_misc();
      t_standby();
      summarize();
   end
endmodule
